// file: rtl/uart_baud_pkg.sv
// constants shared by the serial port and its baud-rate timers
package uart_baud_pkg;

	// register offsets on the plain register port
	localparam logic [3:0] ADDR_T01_MODE   = 4'h0;
	localparam logic [3:0] ADDR_T01_CTRL   = 4'h1;
	localparam logic [3:0] ADDR_T0_LOW     = 4'h2;
	localparam logic [3:0] ADDR_T0_HIGH    = 4'h3;
	localparam logic [3:0] ADDR_T1_LOW     = 4'h4;
	localparam logic [3:0] ADDR_T1_HIGH    = 4'h5;
	localparam logic [3:0] ADDR_T2_CTRL    = 4'h6;
	localparam logic [3:0] ADDR_T2_MODE    = 4'h7;
	localparam logic [3:0] ADDR_T2_LOW     = 4'h8;
	localparam logic [3:0] ADDR_T2_HIGH    = 4'h9;
	localparam logic [3:0] ADDR_T2_CAP_LOW = 4'hA;
	localparam logic [3:0] ADDR_T2_CAP_HI  = 4'hB;
	localparam logic [3:0] ADDR_SER_CTRL   = 4'hC;
	localparam logic [3:0] ADDR_SER_DATA   = 4'hD;
	localparam logic [3:0] ADDR_RATE_CTRL  = 4'hE;

	// timer 0/1 mode register: per timer a 4-bit nibble, mode in [1:0], gate in [3]
	localparam int T01_NIBBLE       = 4;
	localparam int T01_GATE_BIT     = 3;
	// timer 0/1 control register fields
	localparam int T01_RUN0_BIT     = 0;
	localparam int T01_RUN1_BIT     = 1;
	localparam int T01_FLAG0_BIT    = 4;
	localparam int T01_FLAG1_BIT    = 5;
	// timer 2 control register fields
	localparam int T2_FLAG_BIT      = 7;
	localparam int T2_EXT_FLAG_BIT  = 6;
	localparam int T2_RX_CLK_BIT    = 5;
	localparam int T2_TX_CLK_BIT    = 4;
	localparam int T2_EXT_EN_BIT    = 3;
	localparam int T2_RUN_BIT       = 2;
	localparam int T2_COUNTER_BIT   = 1;
	localparam int T2_CAPTURE_BIT   = 0;
	// timer 2 mode register field
	localparam int T2_UPDOWN_BIT    = 0;
	// serial control register fields
	localparam int SER_MODE_HI_BIT  = 7;
	localparam int SER_MODE_LO_BIT  = 6;
	localparam int SER_RX_EN_BIT    = 4;
	localparam int SER_TX_NINTH_BIT = 3;
	localparam int SER_RX_NINTH_BIT = 2;
	localparam int SER_TX_DONE_BIT  = 1;
	localparam int SER_RX_DONE_BIT  = 0;
	// rate control register field
	localparam int DOUBLE_RATE_BIT  = 7;

	// reset values
	localparam logic [7:0]  RESET_BYTE = 8'h00;
	localparam logic [15:0] RESET_WORD = 16'h0000;

	// timing counts
	localparam logic [3:0] MACHINE_CYCLE_LAST = 4'hB;  // twelve system clocks
	localparam logic [3:0] OVERSAMPLE_LAST    = 4'hF;  // sixteen baud clocks per bit
	localparam logic [3:0] SAMPLE_PHASE       = 4'h7;  // middle of a bit
	localparam logic [3:0] FRAME_BITS_8       = 4'hA;  // 10 bits per frame
	localparam logic [3:0] FRAME_BITS_9       = 4'hB;  // 11 bits per frame
	localparam logic [3:0] DATA_BITS_8        = 4'h8;
	localparam logic [3:0] DATA_BITS_9        = 4'h9;

	// timer 0/1 modes
	localparam logic [1:0] TMODE_PRESCALED = 2'b00;
	localparam logic [1:0] TMODE_16BIT     = 2'b01;
	localparam logic [1:0] TMODE_RELOAD    = 2'b10;
	localparam logic [1:0] TMODE_SPLIT     = 2'b11;
	// serial modes
	localparam logic [1:0] SMODE_RESERVED  = 2'b00;
	localparam logic [1:0] SMODE_8BIT_VAR  = 2'b01;
	localparam logic [1:0] SMODE_9BIT_FIX  = 2'b10;
	localparam logic [1:0] SMODE_9BIT_VAR  = 2'b11;

	localparam logic [15:0] COUNT_ALL_ONES = 16'hFFFF;

	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;

endpackage

// file: rtl/uart_baud.sv
// serial port with timer 0/1 and timer 2; timer 1 and timer 2 are the baud-rate sources
//
// Added by the designer: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module uart_baud
	import uart_baud_pkg::*;
(
	input  wire logic       i_clk,
	input  wire logic       i_arst_n,
	input  wire logic [3:0] i_addr,
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_wr,
	input  wire logic       i_rd,
	output logic      [7:0] o_rdata,
	input  wire logic       i_gate_input_zero,
	input  wire logic       i_gate_input_one,
	input  wire logic       i_timer2_count_input_pin,
	input  wire logic       i_timer2_external_control_pin,
	input  wire logic       i_rxd,
	output logic            o_txd
);

	// software-visible state
	logic [7:0]  timer01_mode_register;      // two mode nibbles
	logic [1:0]  run_reg;                    // timer 0/1 run bits
	logic [1:0]  t01_flag_reg;               // timer 0/1 overflow flags
	logic [7:0]  tlo_reg [2];                // timer 0/1 low bytes
	logic [7:0]  thi_reg [2];                // timer 0/1 high bytes
	logic [7:0]  timer2_control_register;    // flags plus control bits
	logic        updown_count_enable_reg;    // timer 2 mode register bit
	logic [15:0] timer2_count_value;         // timer 2 counter
	logic [15:0] timer2_capture_reload_value;
	logic [7:0]  serial_control_register;
	logic [7:0]  rx_buffer_reg;              // last complete byte
	logic        double_rate_bit;
	logic [7:0]  rdata_reg;

	// timing state
	logic [3:0]  mc_cnt_reg;                 // machine-cycle divider
	logic        half_reg;                   // clock/2 divider for timer 2
	logic [1:0]  fix_cnt_reg;                // fixed-rate divider
	logic        ex_prev_reg;                // last external control pin level
	logic        cnt_pin_reg;                // count pin sampled per machine cycle
	logic        tx_half_reg;
	logic        rx_half_reg;

	// decoded controls
	logic        mc_tick;
	logic        half_tick;
	logic [1:0]  ser_mode;
	logic        t2_baud;
	logic        t2_run;
	logic        t2_capture;
	logic        t2_updown;
	logic        t2_up;
	logic        t2_tick;
	logic        ex_fall;
	logic        ex_trig;
	logic        cnt_fall;
	logic        t2_wrap;
	logic        t1_ovf;
	logic [1:0]  tf_set;
	logic [7:0]  lo_nx [2];
	logic [7:0]  hi_nx [2];
	logic        wr_hit;

	assign mc_tick   = (mc_cnt_reg == MACHINE_CYCLE_LAST);
	assign half_tick = half_reg;
	assign ser_mode  = {serial_control_register[SER_MODE_HI_BIT], serial_control_register[SER_MODE_LO_BIT]};
	assign t2_baud   = timer2_control_register[T2_RX_CLK_BIT] | timer2_control_register[T2_TX_CLK_BIT];
	assign t2_run    = timer2_control_register[T2_RUN_BIT];
	assign t2_capture = timer2_control_register[T2_CAPTURE_BIT];
	assign t2_updown = updown_count_enable_reg & ~t2_capture & ~t2_baud;
	assign wr_hit    = i_wr;

	// machine cycle and clock/2 dividers, free running
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			mc_cnt_reg  <= 4'h0;
			half_reg    <= 1'b0;
			fix_cnt_reg <= 2'b00;
		end else begin
			mc_cnt_reg  <= mc_tick ? 4'h0 : mc_cnt_reg + 4'h1;
			half_reg    <= ~half_reg;
			fix_cnt_reg <= fix_cnt_reg + 2'b01;
		end
	end

	// pin edge detectors; count pin looked at once per machine cycle
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ex_prev_reg <= 1'b1;
			cnt_pin_reg <= 1'b1;
		end else begin
			ex_prev_reg <= i_timer2_external_control_pin;
			if (mc_tick)
				cnt_pin_reg <= i_timer2_count_input_pin;
		end
	end
	assign ex_fall  = ex_prev_reg & ~i_timer2_external_control_pin;
	// a pulse must span two machine cycles to be seen, hence clock/24
	assign cnt_fall = mc_tick & cnt_pin_reg & ~i_timer2_count_input_pin;

	// timer 0/1 next values and overflow events
	always_comb begin
		logic [1:0]  md;
		logic        en;
		logic [13:0] s14;
		logic [16:0] s17;
		logic [8:0]  s9;
		md     = 2'b00;
		en     = 1'b0;
		s14    = 14'h0;
		s17    = 17'h0;
		s9     = 9'h0;
		tf_set = 2'b00;
		t1_ovf = 1'b0;
		for (int i = 0; i < 2; i++) begin
			lo_nx[i] = tlo_reg[i];
			hi_nx[i] = thi_reg[i];
			md = timer01_mode_register[i*T01_NIBBLE +: 2];
			// gate input blocks counting while low when gating is on
			en = mc_tick & run_reg[i] & (~timer01_mode_register[i*T01_NIBBLE + T01_GATE_BIT] |
				(i == 0 ? i_gate_input_zero : i_gate_input_one));
			case (md)
				TMODE_PRESCALED: begin
					// low five bits form the divide-by-32 stage
					s14 = {1'b0, thi_reg[i], tlo_reg[i][4:0]} + 14'h1;
					if (en) begin
						hi_nx[i] = s14[12:5];
						lo_nx[i] = {tlo_reg[i][7:5], s14[4:0]};
						if (s14[13]) begin
							tf_set[i] = 1'b1;
							t1_ovf    = (i == 1);
						end
					end
				end
				TMODE_16BIT: begin
					s17 = {1'b0, thi_reg[i], tlo_reg[i]} + 17'h1;
					if (en) begin
						{hi_nx[i], lo_nx[i]} = s17[15:0];
						if (s17[16]) begin
							tf_set[i] = 1'b1;
							t1_ovf    = (i == 1);
						end
					end
				end
				TMODE_RELOAD: begin
					s9 = {1'b0, tlo_reg[i]} + 9'h1;
					if (en) begin
						lo_nx[i] = s9[8] ? thi_reg[i] : s9[7:0];
						if (s9[8]) begin
							tf_set[i] = 1'b1;
							t1_ovf    = (i == 1);
						end
					end
				end
				TMODE_SPLIT: begin
					if (i == 0) begin
						// low byte on its own controls, high byte borrows timer 1 run and flag
						s9 = {1'b0, tlo_reg[0]} + 9'h1;
						if (en) begin
							lo_nx[0] = s9[7:0];
							tf_set[0] = s9[8];
						end
						s9 = {1'b0, thi_reg[0]} + 9'h1;
						if (mc_tick & run_reg[1]) begin
							hi_nx[0] = s9[7:0];
							tf_set[1] = tf_set[1] | s9[8];
						end
					end
					// timer 1 simply holds in this mode
				end
				default: begin
					lo_nx[i] = tlo_reg[i];
				end
			endcase
		end
	end

	// timer 0/1 counters; a software write takes priority over counting
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			for (int i = 0; i < 2; i++) begin
				tlo_reg[i] <= RESET_BYTE;
				thi_reg[i] <= RESET_BYTE;
			end
		end else begin
			for (int i = 0; i < 2; i++) begin
				tlo_reg[i] <= lo_nx[i];
				thi_reg[i] <= hi_nx[i];
			end
			if (wr_hit && i_addr == ADDR_T0_LOW)
				tlo_reg[0] <= i_wdata;
			if (wr_hit && i_addr == ADDR_T0_HIGH)
				thi_reg[0] <= i_wdata;
			if (wr_hit && i_addr == ADDR_T1_LOW)
				tlo_reg[1] <= i_wdata;
			if (wr_hit && i_addr == ADDR_T1_HIGH)
				thi_reg[1] <= i_wdata;
		end
	end

	// timer 0/1 mode and control; overflow set beats a software clear
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			timer01_mode_register <= RESET_BYTE;
			run_reg               <= 2'b00;
			t01_flag_reg          <= 2'b00;
		end else begin
			if (wr_hit && i_addr == ADDR_T01_MODE)
				timer01_mode_register <= i_wdata;
			if (wr_hit && i_addr == ADDR_T01_CTRL) begin
				run_reg      <= {i_wdata[T01_RUN1_BIT], i_wdata[T01_RUN0_BIT]};
				t01_flag_reg <= {i_wdata[T01_FLAG1_BIT], i_wdata[T01_FLAG0_BIT]} | tf_set;
			end else begin
				t01_flag_reg <= t01_flag_reg | tf_set;
			end
		end
	end

	// timer 2 step source: clock/2 as baud source, else pin or machine cycle
	assign t2_tick = t2_baud ? half_tick : (timer2_control_register[T2_COUNTER_BIT] ? cnt_fall : mc_tick);
	assign t2_up   = ~t2_updown | i_timer2_external_control_pin;
	// down counting ends at the reload value, up counting at all ones
	assign t2_wrap = t2_run & t2_tick &
		(t2_up ? (timer2_count_value == COUNT_ALL_ONES) : (timer2_count_value == timer2_capture_reload_value));
	assign ex_trig = timer2_control_register[T2_EXT_EN_BIT] & ex_fall;

	// timer 2 counter
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			timer2_count_value <= RESET_WORD;
		end else begin
			if (t2_run && t2_tick) begin
				if (t2_wrap) begin
					if (t2_capture && !t2_baud)
						timer2_count_value <= RESET_WORD;             // capture mode free-runs upward
					else if (t2_up)
						timer2_count_value <= timer2_capture_reload_value;
					else
						timer2_count_value <= COUNT_ALL_ONES;
				end else if (t2_up) begin
					timer2_count_value <= timer2_count_value + 16'h1;
				end else begin
					timer2_count_value <= timer2_count_value - 16'h1;
				end
			end
			// pin-triggered reload works regardless of the run bit
			if (ex_trig && !t2_baud && !t2_capture && !t2_updown)
				timer2_count_value <= timer2_capture_reload_value;
			if (wr_hit && i_addr == ADDR_T2_LOW)
				timer2_count_value[7:0] <= i_wdata;
			if (wr_hit && i_addr == ADDR_T2_HIGH)
				timer2_count_value[15:8] <= i_wdata;
		end
	end

	// timer 2 capture/reload register
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			timer2_capture_reload_value <= RESET_WORD;
		end else begin
			if (ex_trig && t2_capture && !t2_baud && t2_run)
				timer2_capture_reload_value <= timer2_count_value;
			if (wr_hit && i_addr == ADDR_T2_CAP_LOW)
				timer2_capture_reload_value[7:0] <= i_wdata;
			if (wr_hit && i_addr == ADDR_T2_CAP_HI)
				timer2_capture_reload_value[15:8] <= i_wdata;
		end
	end

	// timer 2 control and mode; flags are set over any same-cycle write
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			timer2_control_register <= RESET_BYTE;
			updown_count_enable_reg <= 1'b0;
		end else begin
			if (wr_hit && i_addr == ADDR_T2_MODE)
				updown_count_enable_reg <= i_wdata[T2_UPDOWN_BIT];
			if (wr_hit && i_addr == ADDR_T2_CTRL)
				timer2_control_register <= i_wdata;
			// no overflow flag while serving the serial port
			if (t2_wrap && !t2_baud)
				timer2_control_register[T2_FLAG_BIT] <= 1'b1;
			// in baud mode the pin edge becomes an extra external event
			if (ex_trig && !t2_updown)
				timer2_control_register[T2_EXT_FLAG_BIT] <= 1'b1;
		end
	end

	// baud clocks at sixteen times the bit rate, one per direction
	logic tx_src;
	logic rx_src;
	logic fixed_tick;
	logic tx_b16;
	logic rx_b16;
	assign tx_src = timer2_control_register[T2_TX_CLK_BIT] ? (t2_wrap & t2_baud) : t1_ovf;
	assign rx_src = timer2_control_register[T2_RX_CLK_BIT] ? (t2_wrap & t2_baud) : t1_ovf;
	// clock/4 or clock/2 baud clock gives clock/64 or clock/32 bit rate
	assign fixed_tick = double_rate_bit ? fix_cnt_reg[0] : (fix_cnt_reg == 2'b11);
	// without doubling every second overflow counts: rate = overflow/32
	assign tx_b16 = (ser_mode == SMODE_9BIT_FIX) ? fixed_tick :
		(tx_src & (double_rate_bit | tx_half_reg));
	assign rx_b16 = (ser_mode == SMODE_9BIT_FIX) ? fixed_tick :
		(rx_src & (double_rate_bit | rx_half_reg));

	// overflow halvers
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			tx_half_reg <= 1'b0;
			rx_half_reg <= 1'b0;
		end else begin
			if (tx_src)
				tx_half_reg <= ~tx_half_reg;
			if (rx_src)
				rx_half_reg <= ~rx_half_reg;
		end
	end

	// transmitter
	logic [10:0] tx_shift_reg;   // frame, lsb leaves first
	logic [3:0]  tx_left_reg;    // bits still to send
	logic [3:0]  tx_phase_reg;   // baud clocks into the current bit
	logic        tx_start;
	logic        tx_done;
	assign tx_start = wr_hit && (i_addr == ADDR_SER_DATA) && (tx_left_reg == 4'h0) &&
		(ser_mode != SMODE_RESERVED);
	assign tx_done  = tx_b16 && (tx_phase_reg == OVERSAMPLE_LAST) && (tx_left_reg == 4'h1);

	// writes while a frame is in flight are ignored
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			tx_shift_reg <= 11'h7FF;
			tx_left_reg  <= 4'h0;
			tx_phase_reg <= 4'h0;
		end else if (tx_start) begin
			tx_phase_reg <= 4'h0;
			if (ser_mode == SMODE_8BIT_VAR) begin
				tx_shift_reg <= {2'b11, i_wdata, 1'b0};
				tx_left_reg  <= FRAME_BITS_8;
			end else begin
				tx_shift_reg <= {1'b1, serial_control_register[SER_TX_NINTH_BIT], i_wdata, 1'b0};
				tx_left_reg  <= FRAME_BITS_9;
			end
		end else if (tx_b16 && tx_left_reg != 4'h0) begin
			tx_phase_reg <= tx_phase_reg + 4'h1;
			if (tx_phase_reg == OVERSAMPLE_LAST) begin
				tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
				tx_left_reg  <= tx_left_reg - 4'h1;
			end
		end
	end

	// line idles high between frames
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n)
			o_txd <= 1'b1;
		else
			o_txd <= (tx_left_reg != 4'h0) ? tx_shift_reg[0] : 1'b1;
	end

	// receiver; shifter is separate from the buffer software reads
	rx_state_t   rx_state_reg;
	logic [3:0]  rx_phase_reg;
	logic [3:0]  rx_count_reg;
	logic [8:0]  rx_shift_reg;
	logic        rx_mid;
	logic        rx_done;
	logic        rx_ninth_next;
	assign rx_mid  = rx_b16 && (rx_phase_reg == SAMPLE_PHASE);
	assign rx_done = (rx_state_reg == RX_STOP) && rx_mid;
	assign rx_ninth_next = (ser_mode == SMODE_8BIT_VAR) ? i_rxd : rx_shift_reg[8];

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rx_state_reg <= RX_IDLE;
			rx_phase_reg <= 4'h0;
			rx_count_reg <= 4'h0;
			rx_shift_reg <= 9'h000;
		end else begin
			if (rx_b16)
				rx_phase_reg <= rx_phase_reg + 4'h1;
			case (rx_state_reg)
				RX_IDLE: begin
					// a low line on a baud clock opens a frame
					if (rx_b16 && !i_rxd && serial_control_register[SER_RX_EN_BIT] &&
						ser_mode != SMODE_RESERVED) begin
						rx_state_reg <= RX_START;
						rx_phase_reg <= 4'h0;
					end
				end
				RX_START: begin
					// a glitch that is high again by mid-bit is dropped
					if (rx_mid) begin
						rx_state_reg <= i_rxd ? RX_IDLE : RX_DATA;
						rx_count_reg <= 4'h0;
					end
				end
				RX_DATA: begin
					if (rx_mid) begin
						rx_shift_reg <= {i_rxd, rx_shift_reg[8:1]};
						rx_count_reg <= rx_count_reg + 4'h1;
						if (rx_count_reg + 4'h1 == ((ser_mode == SMODE_8BIT_VAR) ? DATA_BITS_8 : DATA_BITS_9))
							rx_state_reg <= RX_STOP;
					end
				end
				RX_STOP: begin
					if (rx_mid)
						rx_state_reg <= RX_IDLE;
				end
				default: begin
					rx_state_reg <= RX_IDLE;
				end
			endcase
		end
	end

	// receive buffer loads only at the stop bit, so a new frame may already run
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n)
			rx_buffer_reg <= RESET_BYTE;
		else if (rx_done)
			rx_buffer_reg <= (ser_mode == SMODE_8BIT_VAR) ? rx_shift_reg[8:1] : rx_shift_reg[7:0];
	end

	// serial control; completion flags set over a same-cycle clear
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			serial_control_register <= RESET_BYTE;
			double_rate_bit         <= 1'b0;
		end else begin
			if (wr_hit && i_addr == ADDR_RATE_CTRL)
				double_rate_bit <= i_wdata[DOUBLE_RATE_BIT];
			if (wr_hit && i_addr == ADDR_SER_CTRL)
				serial_control_register <= i_wdata;
			if (rx_done) begin
				serial_control_register[SER_RX_DONE_BIT]  <= 1'b1;
				serial_control_register[SER_RX_NINTH_BIT] <= rx_ninth_next;
			end
			if (tx_done)
				serial_control_register[SER_TX_DONE_BIT] <= 1'b1;
		end
	end

	// read port: data stands the cycle after the strobe, unmapped reads zero
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rdata_reg <= RESET_BYTE;
		end else if (i_rd) begin
			case (i_addr)
				ADDR_T01_MODE:   rdata_reg <= timer01_mode_register;
				ADDR_T01_CTRL:   rdata_reg <= {2'b00, t01_flag_reg, 2'b00, run_reg};
				ADDR_T0_LOW:     rdata_reg <= tlo_reg[0];
				ADDR_T0_HIGH:    rdata_reg <= thi_reg[0];
				ADDR_T1_LOW:     rdata_reg <= tlo_reg[1];
				ADDR_T1_HIGH:    rdata_reg <= thi_reg[1];
				ADDR_T2_CTRL:    rdata_reg <= timer2_control_register;
				ADDR_T2_MODE:    rdata_reg <= {7'h00, updown_count_enable_reg};
				ADDR_T2_LOW:     rdata_reg <= timer2_count_value[7:0];
				ADDR_T2_HIGH:    rdata_reg <= timer2_count_value[15:8];
				ADDR_T2_CAP_LOW: rdata_reg <= timer2_capture_reload_value[7:0];
				ADDR_T2_CAP_HI:  rdata_reg <= timer2_capture_reload_value[15:8];
				ADDR_SER_CTRL:   rdata_reg <= serial_control_register;
				ADDR_SER_DATA:   rdata_reg <= rx_buffer_reg;
				ADDR_RATE_CTRL:  rdata_reg <= {double_rate_bit, 7'h00};
				default:         rdata_reg <= RESET_BYTE;
			endcase
		end else begin
			rdata_reg <= RESET_BYTE;
		end
	end
	assign o_rdata = rdata_reg;

endmodule

// file: testbench/uart_baud_props.sv
// bus and line checker for the serial port block
`timescale 1ns/1ps
module uart_baud_props
	import uart_baud_pkg::*;
(
	input wire logic       i_clk,
	input wire logic       i_arst_n,
	input wire logic [3:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic       i_wr,
	input wire logic       i_rd,
	input wire logic [7:0] o_rdata,
	input wire logic       o_txd
);
	logic [7:0] mode_reg;  // timer 0/1 mode mirror
	logic [1:0] smode_reg; // serial mode mirror
	logic       halt_reg;  // timer 2 can not move
	logic       sent_reg;  // a frame was taken
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);
	// mirrors follow writes; a refused data write leaves the line idle
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			mode_reg <= RESET_BYTE;
			smode_reg <= SMODE_RESERVED;
			halt_reg <= 1'b1;
			sent_reg <= 1'b0;
		end else if (i_wr) begin
			if (i_addr == ADDR_T01_MODE) mode_reg <= i_wdata;
			if (i_addr == ADDR_SER_CTRL) smode_reg <= i_wdata[7:6];
			if (i_addr == ADDR_T2_CTRL) halt_reg <= !i_wdata[T2_RUN_BIT] && !i_wdata[T2_EXT_EN_BIT];
			if (i_addr == ADDR_SER_DATA && smode_reg != SMODE_RESERVED) sent_reg <= 1'b1;
		end
	end
	a_read_quiet: assert property (!i_rd |=> o_rdata == 8'h00) else $error("read data not zero");
	a_unmapped_zero: assert property (i_rd && i_addr == 4'hF |=> o_rdata == 8'h00) else $error("unmapped read");
	a_mode_readback: assert property (i_rd && i_addr == ADDR_T01_MODE |=>
		(o_rdata & 8'hBB) == ($past(mode_reg) & 8'hBB)) else $error("timer mode readback");
	a_smode_readback: assert property (i_rd && i_addr == ADDR_SER_CTRL |=>
		o_rdata[7:6] == $past(smode_reg)) else $error("serial mode readback");
	a_t2_halted: assert property (i_rd && i_addr == ADDR_T2_LOW && halt_reg ##1 !i_wr ##1
		i_rd && i_addr == ADDR_T2_LOW |=> o_rdata == $past(o_rdata, 2)) else $error("timer 2 moved");
	a_low_holds: assert property ($fell(o_txd) |-> !o_txd [*8]) else $error("short low bit");
	a_high_holds: assert property ($rose(o_txd) |-> o_txd [*8]) else $error("short high bit");
	a_idle_high: assert property (!sent_reg |-> o_txd) else $error("line left idle");
	cover property (i_wr && i_addr == ADDR_SER_DATA);
	cover property ($fell(o_txd));
	cover property (i_rd && i_addr == ADDR_SER_DATA);
endmodule
bind uart_baud uart_baud_props i_props (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(i_addr),
	.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_txd(o_txd));

// file: testbench/uart_peer.sv
// remote serial station on the two lines
`timescale 1ns/1ps
module uart_peer #(
	parameter int BIT_CLKS = 32 // clocks per bit at the doubled fixed rate
) (
	input  wire logic i_clk,
	input  wire logic i_line,
	output logic      o_line
);
	initial o_line = 1'b1; // idle high between frames
	// one 11-bit frame out, the block's 9-bit format, at the same rate as the block
	task automatic send(input logic [8:0] v);
		for (int i = 0; i < 11; i++) begin
			@(posedge i_clk);
			o_line <= (i == 0) ? 1'b0 : (i == 10) ? 1'b1 : v[i-1];
			repeat (BIT_CLKS - 1) @(posedge i_clk);
		end
	endtask
	// take a frame in at mid bit; stop level lands in bit 9 of an 11-bit frame, in bit 8 of a 10-bit one
	task automatic recv(output logic [9:0] v);
		@(negedge i_line);
		repeat (BIT_CLKS / 2) @(posedge i_clk);
		for (int i = 0; i < 10; i++) begin
			repeat (BIT_CLKS) @(posedge i_clk);
			v[i] = i_line;
		end
	endtask
endmodule

// file: testbench/tb.sv
// self-checking bench for the serial port with baud timers
`timescale 1ns/1ps
module tb;
	import uart_baud_pkg::*;
	logic       clk = 1'b0;    // 40 MHz
	logic       arst_n = 1'b0; // held low at start
	logic [3:0] addr = 4'h0;   // register bus
	logic [7:0] wdata = 8'h00;
	logic       wr = 1'b0;
	logic       rd = 1'b0;
	logic [7:0] rdata;
	logic       gate0 = 1'b0;  // timer 0 gate
	logic       timer2_external_control_pin = 1'b1;   // timer 2 control pin, idles high
	logic       t2cnt = 1'b1;  // timer 2 count pin, idles high
	logic       rxd;           // from the peer
	logic       txd;
	int         err_count = 0;
	int         tests_run = 0;
	always #12.5 clk = ~clk;
	uart_baud i_dut (.i_clk(clk), .i_arst_n(arst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
		.o_rdata(rdata), .i_gate_input_zero(gate0), .i_gate_input_one(1'b1),
		.i_timer2_count_input_pin(t2cnt), .i_timer2_external_control_pin(timer2_external_control_pin), .i_rxd(rxd), .o_txd(txd));
	uart_peer i_peer (.i_clk(clk), .i_line(txd), .o_line(rxd));
	// compare and count
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// data stands only in the cycle after the strobe
	task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	// two reads exactly gap clocks apart
	task automatic rate(input logic [3:0] a, input int gap, input logic [7:0] inc);
		logic [7:0] v0, v1;
		rd_reg(a, v0);
		repeat (gap - 2) @(posedge clk);
		rd_reg(a, v1);
		chk("count step", {8'h00, v1 - v0}, {8'h00, inc});
	endtask
	task automatic t_regs;
		logic [7:0] v0, v1;
		rd_reg(ADDR_T2_LOW, v0);
		rd_reg(ADDR_T2_LOW, v1);
		chk("timer 2 idle", {8'h00, v1}, {8'h00, v0});
		wr_reg(ADDR_SER_DATA, 8'h55);
		repeat (400) @(posedge clk);
		rd_reg(ADDR_SER_CTRL, v0);
		chk("reserved mode", {8'h00, v0}, 16'h0000);
		rd_reg(4'hF, v0);
		chk("unmapped", {8'h00, v0}, 16'h0000);
	endtask
	task automatic t_timers;
		logic [7:0] v;
		wr_reg(ADDR_T01_MODE, 8'h01);
		wr_reg(ADDR_T01_CTRL, 8'h01);
		rate(ADDR_T0_LOW, 12, 8'h01);
		wr_reg(ADDR_T01_MODE, 8'h00);
		rate(ADDR_T0_HIGH, 384, 8'h01);
		wr_reg(ADDR_T01_MODE, 8'h09);
		rd_reg(ADDR_T01_MODE, v);
		chk("mode readback", {8'h00, v & 8'hBB}, 16'h0009);
		rate(ADDR_T0_LOW, 12, 8'h00);
		@(posedge clk);
		gate0 <= 1'b1;
		rate(ADDR_T0_LOW, 12, 8'h01);
		wr_reg(ADDR_T2_CTRL, 8'h04);
		rate(ADDR_T2_LOW, 12, 8'h01);
		wr_reg(ADDR_T2_CTRL, 8'h14);
		rate(ADDR_T2_LOW, 12, 8'h06);
	endtask
	// timer 1 reload and hold, then timer 2 driven from its two pins
	task automatic t_pins;
		logic [7:0] v, w;
		wr_reg(ADDR_T1_LOW, 8'hFF);
		wr_reg(ADDR_T1_HIGH, 8'h80);
		wr_reg(ADDR_T01_MODE, 8'h29);
		wr_reg(ADDR_T01_CTRL, 8'h03);
		// twelve counting edges before the read: exactly one step
		repeat (11) @(posedge clk);
		rd_reg(ADDR_T1_LOW, v);
		chk("reload value", {8'h00, v}, 16'h0080);
		rd_reg(ADDR_T01_CTRL, v);
		chk("timer flags", {8'h00, v}, 16'h0023);
		wr_reg(ADDR_T01_MODE, 8'h39);
		rate(ADDR_T1_LOW, 12, 8'h00);
		wr_reg(ADDR_T2_MODE, 8'h01);
		wr_reg(ADDR_T2_CTRL, 8'h04);
		@(posedge clk);
		timer2_external_control_pin <= 1'b0;
		rate(ADDR_T2_LOW, 12, 8'hFF);
		@(posedge clk);
		timer2_external_control_pin <= 1'b1;
		wr_reg(ADDR_T2_MODE, 8'h00);
		wr_reg(ADDR_T2_CAP_LOW, 8'h34);
		wr_reg(ADDR_T2_CTRL, 8'h08);
		@(posedge clk);
		timer2_external_control_pin <= 1'b0;
		rd_reg(ADDR_T2_LOW, v);
		chk("pin reload", {8'h00, v}, 16'h0034);
		rd_reg(ADDR_T2_CTRL, v);
		chk("pin flag", {8'h00, v}, 16'h0048);
		wr_reg(ADDR_T2_CTRL, 8'h06);
		rd_reg(ADDR_T2_LOW, v);
		@(posedge clk);
		// four pulses at the fastest accepted rate
		repeat (4) begin
			t2cnt <= 1'b0;
			repeat (12) @(posedge clk);
			t2cnt <= 1'b1;
			repeat (12) @(posedge clk);
		end
		rd_reg(ADDR_T2_LOW, w);
		chk("pin count", {8'h00, w - v}, 16'h0004);
	endtask
	// both directions at once, then two frames in before one read
	task automatic t_link(input logic [7:0] sctl);
		logic [9:0] f;
		logic [7:0] v;
		wr_reg(ADDR_RATE_CTRL, 8'h80);
		wr_reg(ADDR_SER_CTRL, sctl);
		fork
			wr_reg(ADDR_SER_DATA, 8'hA5);
			i_peer.recv(f);
			i_peer.send(9'h1C3);
		join
		chk("sent frame", {6'h00, f}, 16'h03A5);
		i_peer.send(9'h15A);
		repeat (40) @(posedge clk);
		rd_reg(ADDR_SER_DATA, v);
		chk("received byte", {8'h00, v}, 16'h005A);
		rd_reg(ADDR_SER_CTRL, v);
		chk("serial flags", {8'h00, v}, {8'h00, sctl | 8'h07});
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
		t_regs;
		t_timers;
		t_pins;
		t_link(8'h98);
		// timer 2 wraps on every step: same bit time as the fixed rate
		wr_reg(ADDR_T2_CTRL, 8'h00);
		for (int a = 8; a < 12; a++)
			wr_reg(4'(a), 8'hFF);
		wr_reg(ADDR_T2_CTRL, 8'h34);
		t_link(8'hD8);
		t_link(8'h58);
		give_verdict;
	end
	// about 3300 clocks are needed
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		give_verdict;
	end
endmodule
